// File: verif/dmt_pin_model.sv
/*
 Far-side pin model: timer, direction and capture pins of the timer.
 Assumes the bench calls set() from one process at a time.
*/
`timescale 1ns/10ps
`default_nettype none

module dmt_pin_model (
    input  wire logic       clk,
    output var  logic [4:0] tin,
    output var  logic [4:0] dir,
    output var  logic       cap
);
    // pins rest low
    initial begin
        tin = 5'h00;
        dir = 5'h00;
        cap = 1'b0;
    end

    // hold 8 clocks: sync latency plus one event window
    task automatic set(input int b, input logic a, input logic bb, input logic c);
        @(posedge clk);
        tin[b] <= a;
        dir[b] <= bb;
        cap    <= c;
        repeat (8) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// File: verif/dmt_props.sv
/*
 Checker for the dual-module timer: bus answer timing, read width and
 pacing of the toggle and capture/compare clock outputs.
 Assumes it is bound into dmt_top with the top module's port names.
*/
`timescale 1ns/10ps
`default_nettype none

module dmt_props (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic [7:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        CORE_TOGGLE_OUTPUT,
    input wire logic        SECOND_TOGGLE_OUTPUT,
    input wire logic        CAPTURE_COMPARE_CLOCK
);
    // one clock domain, reset masks every check
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    chk_read_width: assert property (
        S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0)
        else $error("read data upper half not zero");
    // a step comes at most every 4 clocks, so the latch cannot move faster
    chk_core_pace: assert property (
        $changed(CORE_TOGGLE_OUTPUT) |=> $stable(CORE_TOGGLE_OUTPUT)[*3])
        else $error("core toggle output changed too soon");
    chk_second_pace: assert property (
        $changed(SECOND_TOGGLE_OUTPUT) |=> $stable(SECOND_TOGGLE_OUTPUT))
        else $error("second toggle output changed too soon");
    chk_ccu_pulse: assert property (
        CAPTURE_COMPARE_CLOCK |=> !CAPTURE_COMPARE_CLOCK)
        else $error("capture compare clock pulse too long");
    chk_unmapped_read: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR > 8'h30 || S_AXI_ARADDR[1:0] != 2'h0)
        |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
    chk_write_answer: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    chk_read_answer: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read response late");
    chk_ar_block: assert property (
        S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address taken while answer pending");
    chk_aw_block: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("write address slot not closed");
endmodule

bind dmt_top dmt_props u_props (.*);

`default_nettype wire

// File: verif/dual_module_general_timer_test.sv
/*
 Self-checking bench for the dual-module timer: AXI4-Lite tasks, pin
 model, integer model of counts and intervals.
 Assumes dmt_top, dmt_pin_model, dmt_props and a 250 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dmt_defs.vh"

module dual_module_general_timer_test;
    logic        CLOCK = 1'b0;
    logic        RST = 1'b1;
    logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0;
    logic [3:0]  S_AXI_WSTRB = 4'hf;
    logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    wire  [31:0] S_AXI_RDATA;
    wire  [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    wire         CORE_TOGGLE_OUTPUT, SECOND_TOGGLE_OUTPUT, CAPTURE_COMPARE_CLOCK;
    wire  [4:0]  TIMER_INPUT_PIN, DIRECTION_INPUT_PIN;
    wire         CAPTURE_INPUT_PIN;
    wire  [2:0]  obs = {CAPTURE_COMPARE_CLOCK, SECOND_TOGGLE_OUTPUT, CORE_TOGGLE_OUTPUT};
    int          num_errors = 0, checked = 0;
    int          n, hi, lo, ph, mdl[5]; // mdl: expected counter values
    logic [31:0] d, v;
    logic [1:0]  r;

    dmt_top dut (.*);
    dmt_pin_model pins (.clk(CLOCK), .tin(TIMER_INPUT_PIN), .dir(DIRECTION_INPUT_PIN),
                        .cap(CAPTURE_INPUT_PIN));

    always #2 CLOCK = ~CLOCK;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // AW and W together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
        logic ap, wp;
        @(posedge CLOCK);
        S_AXI_AWADDR  <= a;
        S_AXI_WDATA   <= dat;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID  <= 1'b1;
        S_AXI_BREADY  <= 1'b1;
        ap = 1'b1;
        wp = 1'b1;
        while (ap || wp) begin
            @(posedge CLOCK);
            if (ap && S_AXI_AWREADY === 1'b1) begin
                S_AXI_AWVALID <= 1'b0;
                ap = 1'b0;
            end
            if (wp && S_AXI_WREADY === 1'b1) begin
                S_AXI_WVALID <= 1'b0;
                wp = 1'b0;
            end
        end
        do @(posedge CLOCK); while (S_AXI_BVALID !== 1'b1);
        S_AXI_BREADY <= 1'b0;
        chk({30'h0, S_AXI_BRESP}, {30'h0, er});
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge CLOCK);
        S_AXI_ARADDR  <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY  <= 1'b1;
        do @(posedge CLOCK); while (S_AXI_ARREADY !== 1'b1);
        S_AXI_ARVALID <= 1'b0;
        do @(posedge CLOCK); while (S_AXI_RVALID !== 1'b1);
        S_AXI_RREADY <= 1'b0;
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        chk(d & e, e);
        chk({30'h0, r}, {30'h0, er});
    endtask

    // clocks until the watched output is sampled at level l
    task automatic span(input int s, input logic l, output int c);
        c = 0;
        do begin
            @(posedge CLOCK);
            c++;
        end while (obs[s] !== l);
    endtask

    initial begin
        void'($urandom(32'h9fde));
        repeat (20) @(posedge CLOCK);
        RST <= 1'b0;
        repeat (3) @(posedge CLOCK);
        for (int a = 0; a <= 'h30; a += 4) begin
            rchk(8'(a), 32'h0, `DMT_OKAY);
            chk(d, 32'h0);
        end
        rchk(8'h34, 32'h0, `DMT_SLVERR);
        rchk(8'h02, 32'h0, `DMT_SLVERR);
        wr(8'h40, 32'h1234, `DMT_SLVERR);
        for (int i = 0; i < 5; i++) begin
            v = $urandom;
            wr(`DMT_A_CNT0 + 8'(4 * i), v, `DMT_OKAY);
            rchk(`DMT_A_CNT0 + 8'(4 * i), {16'h0, v[15:0]}, `DMT_OKAY);
            chk(d, {16'h0, v[15:0]});
        end
        // counter mode: up, software down, pin down
        for (int k = 0; k < 3; k++) begin
            wr(`DMT_A_CNT2, 32'h0, `DMT_OKAY);
            wr(`DMT_A_CTL2, k == 0 ? 32'h0830 : k == 1 ? 32'h0870 : 32'h08b0, `DMT_OKAY);
            pins.set(2, 1'b0, k == 2, 1'b0);
            n = 1 + $urandom % 6;
            repeat (n) begin
                pins.set(2, 1'b1, k == 2, 1'b0);
                pins.set(2, 1'b0, k == 2, 1'b0);
            end
            mdl[2] = k == 0 ? n : -n;
            rchk(`DMT_A_CNT2, 32'(mdl[2]) & 32'hffff, `DMT_OKAY);
            chk(d, 32'(mdl[2]) & 32'hffff);
        end
        // gated: closed gate holds, open counts ~200/4
        pins.set(2, 1'b0, 1'b0, 1'b0);
        wr(`DMT_A_CNT2, 32'h0, `DMT_OKAY);
        wr(`DMT_A_CTL2, 32'h0128, `DMT_OKAY);
        repeat (100) @(posedge CLOCK);
        rchk(`DMT_A_CNT2, 32'h0, `DMT_OKAY);
        chk(d, 32'h0);
        pins.set(2, 1'b1, 1'b0, 1'b0);
        repeat (192) @(posedge CLOCK);
        pins.set(2, 1'b0, 1'b0, 1'b0);
        rchk(`DMT_A_CNT2, 32'h0, `DMT_OKAY);
        chk(32'(d >= 49 && d <= 51), 32'h1);
        wr(`DMT_A_CTL2, 32'h0, `DMT_OKAY);
        // encoder on aux low, random walk of quarter steps
        wr(`DMT_A_CNT0, 32'h0, `DMT_OKAY);
        wr(`DMT_A_CTL0, 32'h0038, `DMT_OKAY);
        ph = 0;
        mdl[0] = 0;
        for (int s = 0; s < 24; s++) begin
            n = ($urandom % 4 != 0) ? 1 : 3;
            ph = (ph + n) % 4;
            mdl[0] += (n == 1) ? 1 : -1;
            pins.set(0, ph == 1 || ph == 2, ph >= 2, 1'b0);
        end
        rchk(`DMT_A_CNT0, 32'(mdl[0]) & 32'hffff, `DMT_OKAY);
        chk(d, 32'(mdl[0]) & 32'hffff);
        wr(`DMT_A_CTL0, 32'h0, `DMT_OKAY);
        pins.set(0, 1'b0, 1'b0, 1'b0);
        // aux low captures the stopped core on a pin rise
        v = $urandom;
        wr(`DMT_A_CTL0, 32'h0a00, `DMT_OKAY);
        wr(`DMT_A_CNT1, v, `DMT_OKAY);
        pins.set(0, 1'b1, 1'b0, 1'b0);
        pins.set(0, 1'b0, 1'b0, 1'b0);
        rchk(`DMT_A_CNT0, 32'h0, `DMT_OKAY);
        chk(d, {16'h0, v[15:0]});
        // capture register: capture pin with clear, then core count pin
        for (int k = 0; k < 2; k++) begin
            v = $urandom;
            wr(`DMT_A_CNT3, v, `DMT_OKAY);
            wr(`DMT_A_CAPC, k == 0 ? 32'h5 : 32'h9, `DMT_OKAY);
            pins.set(k, 1'b0, 1'b0, k == 0);
            pins.set(k, k == 1, 1'b0, 1'b0);
            pins.set(k, 1'b0, 1'b0, 1'b0);
            rchk(`DMT_A_CAPR, 32'h0, `DMT_OKAY);
            chk(d, {16'h0, v[15:0]});
            rchk(`DMT_A_CNT3, 32'h0, `DMT_OKAY);
            chk(d, k == 0 ? 32'h0 : {16'h0, v[15:0]});
        end
        // two aux reloads on opposite latch edges make a free PWM
        wr(`DMT_A_STAT, 32'h7f, `DMT_OKAY);
        wr(`DMT_A_CTL0, 32'h2c00, `DMT_OKAY);
        wr(`DMT_A_CTL2, 32'h3400, `DMT_OKAY);
        wr(`DMT_A_CNT0, 32'hfff0, `DMT_OKAY);
        wr(`DMT_A_CNT2, 32'hffe0, `DMT_OKAY);
        wr(`DMT_A_CNT1, 32'hffe0, `DMT_OKAY);
        for (int p = 0; p < 2; p++) begin
            wr(`DMT_A_CTL1, 32'h0, `DMT_OKAY);
            wr(`DMT_A_CTL1, 32'h4020 | p, `DMT_OKAY);
            span(0, 1'b1, n);
            span(0, 1'b0, n);
            span(0, 1'b1, n);
            span(0, 1'b0, hi);
            span(0, 1'b1, lo);
            chk(32'(hi), 32'(16 * (4 << p)));
            chk(32'(lo), 32'(32 * (4 << p)));
        end
        wr(`DMT_A_CTL1, 32'h0, `DMT_OKAY);
        rchk(`DMT_A_STAT, 32'h0, `DMT_OKAY);
        chk(d & 32'h1f, 32'h2);
        rchk(`DMT_A_CNT0, 32'hfff0, `DMT_OKAY);
        wr(`DMT_A_STAT, 32'h2, `DMT_OKAY);
        rchk(`DMT_A_STAT, 32'h0, `DMT_OKAY);
        chk(d & 32'h1f, 32'h0);
        // second core reloads from the capture register on every wrap
        wr(`DMT_A_CAPR, 32'hfff8, `DMT_OKAY);
        wr(`DMT_A_CNT4, 32'hfff8, `DMT_OKAY);
        for (int p = 0; p < 2; p++) begin
            wr(`DMT_A_CTL4, 32'h0, `DMT_OKAY);
            wr(`DMT_A_CTL4, 32'hc020 | p, `DMT_OKAY);
            span(2, 1'b1, n);
            span(2, 1'b1, n);
            chk(32'(n), 32'(8 * (2 << p)));
            span(1, 1'b0, n);
            span(1, 1'b1, n);
            span(1, 1'b0, n);
            chk(32'(n), 32'(8 * (2 << p)));
        end
        wr(`DMT_A_CTL4, 32'h0, `DMT_OKAY);
        tally_and_finish();
    end

    // hang guard
    initial begin
        repeat (40000) @(posedge CLOCK);
        num_errors++;
        tally_and_finish();
    end
endmodule

`default_nettype wire

// File: verilog/dmt_defs.vh
/*
 Register offsets, field positions, reset values, mode codes and
 resolution shifts for the dual-module general timer.
 Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
`ifndef DMT_DEFS_VH
`define DMT_DEFS_VH

// register byte offsets
`define DMT_A_CTL0   8'h00
`define DMT_A_CTL1   8'h04
`define DMT_A_CTL2   8'h08
`define DMT_A_CTL3   8'h0c
`define DMT_A_CTL4   8'h10
`define DMT_A_CNT0   8'h14
`define DMT_A_CNT1   8'h18
`define DMT_A_CNT2   8'h1c
`define DMT_A_CNT3   8'h20
`define DMT_A_CNT4   8'h24
`define DMT_A_CAPR   8'h28
`define DMT_A_CAPC   8'h2c
`define DMT_A_STAT   8'h30

// timer control fields
`define DMT_F_PS     2:0
`define DMT_F_MODE   4:3
`define DMT_B_RUN    5
`define DMT_B_DN     6
`define DMT_B_PINDIR 7
`define DMT_B_GATE   8
`define DMT_F_SPEC   10:9
`define DMT_F_EDGE   12:11
`define DMT_B_LSRC   13
`define DMT_B_OUTEN  14
`define DMT_B_RELCR  15

// capture control fields
`define DMT_F_CEDGE  1:0
`define DMT_B_CCLR   2
`define DMT_B_CT3IN  3
`define DMT_B_CT3DIR 4

// reset values
`define DMT_CTL_RST  16'h0000
`define DMT_CAPC_RST 5'h00

// operating modes and aux roles
`define DMT_M_TMR    2'h0
`define DMT_M_GATE   2'h1
`define DMT_M_CNT    2'h2
`define DMT_M_ENC    2'h3
`define DMT_S_CAP    2'h1
`define DMT_S_REL    2'h2

// log2 of finest resolution: 4 clocks and 2 clocks
`define DMT_SH1      2'h2
`define DMT_SH2      2'h1

// bus responses
`define DMT_OKAY     2'h0
`define DMT_SLVERR   2'h2

`endif

// File: verilog/dmt_sync.v
/*
 Two-flop input synchroniser with edge detection on the settled level.
 Assumes inputs are asynchronous pins, held per the pin timing.
*/
`timescale 1ns/10ps
`default_nettype none

module dmt_sync #(
    parameter W = 11
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] din,
    output wire [W-1:0] lvl,
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);
    reg [W-1:0] s1_r;  // metastable stage, read only by s2_r
    reg [W-1:0] s2_r;  // settled level
    reg [W-1:0] s3_r;  // previous settled level

    // sync chain plus one history stage for edges
    always @(posedge clk) begin
        if (rst) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign lvl  = s2_r;
    assign rise = s2_r & ~s3_r;
    assign fall = ~s2_r & s3_r;
endmodule

`default_nettype wire

// File: verilog/dmt_timer.v
/*
 One 16-bit up/down counter with load and wrap pulse.
 Assumes step, direction and load come from the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module dmt_timer #(
    parameter W = 16
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         step,
    input  wire         dn,
    input  wire         ld,
    input  wire [W-1:0] ld_val,
    output wire [W-1:0] cnt,
    output wire         wrap
);
    reg [W-1:0] cnt_r;  // counter value

    // load beats stepping; wrap still reported so a reload can ride on it
    always @(posedge clk) begin
        if (rst)
            cnt_r <= {W{1'b0}};
        else if (ld)
            cnt_r <= ld_val;
        else if (step)
            cnt_r <= dn ? cnt_r - 1'b1 : cnt_r + 1'b1;
    end

    assign cnt  = cnt_r;
    assign wrap = step & (dn ? ~|cnt_r : &cnt_r);
endmodule

`default_nettype wire

// File: verilog/dmt_top.v
/*
 Dual-module general timer: three first-module timers (aux low, core,
 aux high) and two second-module timers (second aux, second core) with
 a capture/reload register, configured over AXI4-Lite.
 Assumes one 250 MHz clock, synchronous active-high reset, async pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dmt_defs.vh"

module dmt_top (
    input  wire        CLOCK,
    input  wire        RST,
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    input  wire [4:0]  TIMER_INPUT_PIN,
    input  wire [4:0]  DIRECTION_INPUT_PIN,
    input  wire        CAPTURE_INPUT_PIN,
    output reg         CORE_TOGGLE_OUTPUT,
    output reg         SECOND_TOGGLE_OUTPUT,
    output reg         CAPTURE_COMPARE_CLOCK
);
    // register index from byte address, 4'hf when unmapped
    function [3:0] aidx;
        input [7:0] a;
        aidx = (a[1:0] == 2'h0 && a <= `DMT_A_STAT) ? a[5:2] : 4'hf;
    endfunction

    // edge select: bit0 rising, bit1 falling, both for any
    function esel;
        input       r;
        input       f;
        input [1:0] s;
        begin
            esel = (s[0] & r) | (s[1] & f);
        end
    endfunction

    // prescaler tick every 2^(ps+sh) clocks
    function ptick;
        input [9:0] c;
        input [2:0] ps;
        input [1:0] sh;
        reg   [9:0] m;
        begin
            m = (10'h001 << ({1'b0, ps} + {2'h0, sh})) - 10'h001;
            ptick = ~|(c & m);
        end
    endfunction

    // 16-bit merge under the two low byte strobes
    function [15:0] wmrg;
        input [15:0] o;
        input [15:0] d;
        input [1:0]  s;
        begin
            wmrg = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
        end
    endfunction

    // bus state
    reg        aw_ok_r;           // write address held
    reg        w_ok_r;            // write data held
    reg [7:0]  awa_r;             // held write address
    reg [31:0] wd_r;              // held write data
    reg [3:0]  ws_r;              // held write strobes
    reg [31:0] rd_nxt;            // read mux
    reg        rok_nxt;           // read address mapped

    // timer state
    reg [15:0] ctl_r [0:4];       // per-timer control
    reg [4:0]  capc_r;            // capture control
    reg [15:0] capreg_r;          // capture/reload register
    reg [4:0]  flag_r;            // sticky wrap flags
    reg        tl_r;              // core toggle latch
    reg        tl2_r;             // second toggle latch
    reg [9:0]  pre_r;             // shared free-running prescaler

    wire [4:0]  tl_s;             // synced timer input levels
    wire [4:0]  tr_s;             // timer input rising
    wire [4:0]  tf_s;             // timer input falling
    wire [4:0]  dl_s;             // synced direction levels
    wire [4:0]  dr_s;             // direction rising
    wire [4:0]  df_s;             // direction falling
    wire        cr_s;             // capture pin rising
    wire        cf_s;             // capture pin falling
    wire [15:0] tv [0:4];         // timer values
    wire [15:0] hv [0:4];         // hardware load values
    wire [15:0] lv [0:4];         // final load values
    wire [4:0]  wr;               // wrap pulses
    wire [4:0]  step;             // count steps
    wire [4:0]  dn;               // count down
    wire [4:0]  hw_ld;            // hardware loads
    wire [4:0]  sw_ld;            // software loads
    wire [4:0]  capv;             // aux capture triggers
    wire [4:0]  relv;             // aux reload triggers

    wire unused_cl;               // capture level itself is not needed

    // all pins through two flops before any logic
    dmt_sync #(.W(11)) u_sync (
        .clk  (CLOCK),
        .rst  (RST),
        .din  ({CAPTURE_INPUT_PIN, DIRECTION_INPUT_PIN, TIMER_INPUT_PIN}),
        .lvl  ({unused_cl, dl_s, tl_s}),
        .rise ({cr_s, dr_s, tr_s}),
        .fall ({cf_s, df_s, tf_s})
    );

    // write handshake, address and data in either order
    wire do_wr  = aw_ok_r & w_ok_r & ~S_AXI_BVALID;
    wire aw_nxt = do_wr ? 1'b0 : (aw_ok_r | (S_AXI_AWVALID & S_AXI_AWREADY));
    wire w_nxt  = do_wr ? 1'b0 : (w_ok_r | (S_AXI_WVALID & S_AXI_WREADY));
    wire rv_nxt = (S_AXI_ARVALID & S_AXI_ARREADY) | (S_AXI_RVALID & ~S_AXI_RREADY);
    wire [3:0] wix = aidx(awa_r);

    // latch transitions come straight from the wrap pulse
    wire tl_rise  = wr[1] & ~tl_r;
    wire tl_fall  = wr[1] & tl_r;
    wire tl2_rise = wr[4] & ~tl2_r;
    wire tl2_fall = wr[4] & tl2_r;
    // one base tick per finest step of each module
    wire btk1 = ptick(pre_r, 3'h0, `DMT_SH1);
    wire btk2 = ptick(pre_r, 3'h0, `DMT_SH2);

    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_t
            wire [15:0] c   = ctl_r[i];
            wire        sec = (i > 2);
            // second module knows only timer and counter
            wire [1:0]  md  = sec ? {c[4], 1'b0} : c[`DMT_F_MODE];
            wire        tk  = ptick(pre_r, c[`DMT_F_PS],
                                    sec ? `DMT_SH2 : `DMT_SH1);
            wire        bt  = sec ? btk2 : btk1;
            wire        lsrc = c[`DMT_B_LSRC] & (i == 0 || i == 2 || i == 3);
            wire        lr  = (i == 3) ? tl2_rise : tl_rise;
            wire        lf  = (i == 3) ? tl2_fall : tl_fall;
            // event source: pin edge or toggle latch edge
            wire        pev = lsrc ? esel(lr, lf, c[`DMT_F_EDGE])
                                   : esel(tr_s[i], tf_s[i], c[`DMT_F_EDGE]);
            wire        ach = tr_s[i] | tf_s[i];
            wire        bch = dr_s[i] | df_s[i];
            // phase relation gives direction of travel
            wire        eup = ach ? (tl_s[i] ^ dl_s[i]) : ~(tl_s[i] ^ dl_s[i]);
            wire        enc = (md == `DMT_M_ENC) & (ach | bch);
            wire        ev  = ((md == `DMT_M_CNT) & pev) | enc;
            wire        spec = ~sec & (i != 1) & (c[`DMT_F_SPEC] != 2'h0);
            wire        dsel = c[`DMT_B_PINDIR] ? dl_s[i] : c[`DMT_B_DN];
            reg         pend_r;   // event waiting for a base tick
            reg         pdn_r;    // direction of that event

            // events park until the next base tick; a second event inside
            // one tick window merges with the first, the price
            always @(posedge CLOCK) begin
                if (RST) begin
                    pend_r <= 1'b0;
                    pdn_r  <= 1'b0;
                end else begin
                    pend_r <= ev | (pend_r & ~bt);
                    if (ev)
                        pdn_r <= (md == `DMT_M_ENC) ? ~eup : dsel;
                end
            end

            // aux in capture or reload role stands still
            assign step[i] = c[`DMT_B_RUN] & ~spec &
                ((md == `DMT_M_TMR)  ? tk :
                 (md == `DMT_M_GATE) ? (tk & (tl_s[i] == c[`DMT_B_GATE])) :
                 (bt & pend_r));
            assign dn[i]   = md[1] ? pdn_r : dsel;
            assign capv[i] = spec & (c[`DMT_F_SPEC] == `DMT_S_CAP) & pev;
            assign relv[i] = spec & (c[`DMT_F_SPEC] == `DMT_S_REL) & pev;
            assign sw_ld[i] = do_wr & (wix == (4'h5 + i));
            assign lv[i]   = sw_ld[i] ? wd_r[15:0] : hv[i];

            // each timer is a plain 16-bit wrapping counter
            dmt_timer #(.W(16)) u_tmr (
                .clk    (CLOCK),
                .rst    (RST),
                .step   (step[i]),
                .dn     (dn[i]),
                .ld     (sw_ld[i] | hw_ld[i]),
                .ld_val (lv[i]),
                .cnt    (tv[i]),
                .wrap   (wr[i])
            );
        end
    endgenerate

    // capture trigger: capture pin, or core count/direction pins
    wire [1:0] cedg = capc_r[`DMT_F_CEDGE];
    wire alt_src = capc_r[`DMT_B_CT3IN] | capc_r[`DMT_B_CT3DIR];
    wire cap_ev = alt_src ?
        ((capc_r[`DMT_B_CT3IN] & esel(tr_s[1], tf_s[1], cedg)) |
         (capc_r[`DMT_B_CT3DIR] & esel(dr_s[1], df_s[1], cedg))) :
        esel(cr_s, cf_s, cedg);

    // hardware loads; chaining stays inside each module
    assign hw_ld[0] = capv[0];
    assign hv[0]    = tv[1];
    assign hw_ld[2] = capv[2];
    assign hv[2]    = tv[1];
    // both reloads on opposite latch edges alternate the core period
    assign hw_ld[1] = relv[0] | relv[2];
    assign hv[1]    = relv[0] ? tv[0] : tv[2];
    assign hw_ld[3] = cap_ev & capc_r[`DMT_B_CCLR];
    assign hv[3]    = 16'h0000;
    assign hw_ld[4] = wr[4] & ctl_r[4][`DMT_B_RELCR];
    assign hv[4]    = capreg_r;

    // read data selection
    always @* begin
        rok_nxt = 1'b1;
        rd_nxt  = 32'h0000_0000;
        case (aidx(S_AXI_ARADDR))
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4:
                rd_nxt[15:0] = ctl_r[S_AXI_ARADDR[4:2]];
            4'h5: rd_nxt[15:0] = tv[0];
            4'h6: rd_nxt[15:0] = tv[1];
            4'h7: rd_nxt[15:0] = tv[2];
            4'h8: rd_nxt[15:0] = tv[3];
            4'h9: rd_nxt[15:0] = tv[4];
            4'ha: rd_nxt[15:0] = capreg_r;
            4'hb: rd_nxt[4:0]  = capc_r;
            4'hc: rd_nxt[6:0]  = {tl2_r, tl_r, flag_r};
            default: rok_nxt = 1'b0;
        endcase
    end

    // bus slave: one write and one read in flight
    always @(posedge CLOCK) begin
        if (RST) begin
            aw_ok_r       <= 1'b0;
            w_ok_r        <= 1'b0;
            awa_r         <= 8'h00;
            wd_r          <= 32'h0000_0000;
            ws_r          <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `DMT_OKAY;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= `DMT_OKAY;
        end else begin
            aw_ok_r       <= aw_nxt;
            w_ok_r        <= w_nxt;
            S_AXI_AWREADY <= ~aw_nxt;
            S_AXI_WREADY  <= ~w_nxt;
            if (S_AXI_AWVALID & S_AXI_AWREADY)
                awa_r <= S_AXI_AWADDR;
            if (S_AXI_WVALID & S_AXI_WREADY) begin
                wd_r <= S_AXI_WDATA;
                ws_r <= S_AXI_WSTRB;
            end
            // response follows the write by one edge
            if (do_wr) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (wix == 4'hf) ? `DMT_SLVERR : `DMT_OKAY;
            end else if (S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
            S_AXI_ARREADY <= ~rv_nxt;
            if (S_AXI_ARVALID & S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rd_nxt;
                S_AXI_RRESP  <= rok_nxt ? `DMT_OKAY : `DMT_SLVERR;
            end else if (S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

    // control registers, capture register, flags, latches, outputs
    integer k;
    always @(posedge CLOCK) begin
        if (RST) begin
            for (k = 0; k < 5; k = k + 1)
                ctl_r[k] <= `DMT_CTL_RST;
            capc_r                <= `DMT_CAPC_RST;
            capreg_r              <= 16'h0000;
            flag_r                <= 5'h00;
            tl_r                  <= 1'b0;
            tl2_r                 <= 1'b0;
            pre_r                 <= 10'h000;
            CORE_TOGGLE_OUTPUT    <= 1'b0;
            SECOND_TOGGLE_OUTPUT  <= 1'b0;
            CAPTURE_COMPARE_CLOCK <= 1'b0;
        end else begin
            pre_r <= pre_r + 10'h001;
            for (k = 0; k < 5; k = k + 1)
                if (do_wr && wix == k[3:0])
                    ctl_r[k] <= wmrg(ctl_r[k], wd_r[15:0], ws_r[1:0]);
            if (do_wr && wix == 4'hb && ws_r[0])
                capc_r <= wd_r[4:0];
            // a hardware capture beats a software write the same cycle
            if (cap_ev)
                capreg_r <= tv[3];
            else if (do_wr && wix == 4'ha)
                capreg_r <= wmrg(capreg_r, wd_r[15:0], ws_r[1:0]);
            // wrap sets win over a write-one clear
            if (do_wr && wix == 4'hc && ws_r[0])
                flag_r <= (flag_r & ~wd_r[4:0]) | wr;
            else
                flag_r <= flag_r | wr;
            if (wr[1])
                tl_r <= ~tl_r;
            if (wr[4])
                tl2_r <= ~tl2_r;
            CORE_TOGGLE_OUTPUT    <= tl_r & ctl_r[1][`DMT_B_OUTEN];
            SECOND_TOGGLE_OUTPUT  <= tl2_r & ctl_r[4][`DMT_B_OUTEN];
            CAPTURE_COMPARE_CLOCK <= wr[4];
        end
    end
endmodule

`default_nettype wire
